// ---- rtl/lcim_regs.svh ----
`ifndef LCIM_REGS_SVH
`define LCIM_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define LCIM_IDX_W          11
`define LCIM_CH_STRIDE      11'h040
`define LCIM_CH1_BASE_IDX   11'h01B
`define LCIM_CH9_BASE_IDX   11'h21B
`define LCIM_GMASK0_IDX     11'h7DB

// Offsets inside one channel block of 0x40 indices.
`define LCIM_OFS_EDGE_SEL   6'h1A
`define LCIM_OFS_MASK0      6'h1B
`define LCIM_OFS_MASK1      6'h1C
`define LCIM_OFS_MASK2      6'h1D
`define LCIM_OFS_LIVE_CONDITION_STATUS0      6'h1E
`define LCIM_OFS_STAT1      6'h1F
`define LCIM_OFS_FLAG0      6'h20
`define LCIM_OFS_FLAG1      6'h21
`define LCIM_OFS_FLAG2      6'h22

// ----------------------------------------------------------------------------
// Implemented bits and reset values
// ----------------------------------------------------------------------------
`define LCIM_BITS_GROUP0    8'hFF
`define LCIM_BITS_GROUP1    8'hE3
`define LCIM_BITS_GROUP2    8'h3F
`define LCIM_BITS_LIVE_CONDITION_STATUS0     8'h9F
`define LCIM_BITS_EDGE_SEL  8'h7F
`define LCIM_RST_MASK0      8'hFF
`define LCIM_RST_MASK1      8'hE3
`define LCIM_RST_MASK2      8'h3F
`define LCIM_RST_STAT       8'h00
`define LCIM_RST_EDGE_SEL   8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LCIM_LIVE_CONDITION_STATUS0_AUTOLOOP 7
`define LCIM_ES_AIS         6
`define LCIM_ES_PA          5
`define LCIM_ES_TOC         4
`define LCIM_ES_TCKLOS      3
`define LCIM_ES_TLOS        2
`define LCIM_ES_LOS         1
`define LCIM_ES_IB          0

`endif

// ---- rtl/lcim_pkg.sv ----
package lcim_pkg;

   typedef logic [7:0] lcim_byte_t;

   typedef enum logic [3:0] {
      LCIM_SEL_NONE,
      LCIM_SEL_EDGE_SEL,
      LCIM_SEL_MASK0,
      LCIM_SEL_MASK1,
      LCIM_SEL_MASK2,
      LCIM_SEL_LIVE_CONDITION_STATUS0,
      LCIM_SEL_STAT1,
      LCIM_SEL_FLAG0,
      LCIM_SEL_FLAG1,
      LCIM_SEL_FLAG2,
      LCIM_SEL_GMASK0
   } lcim_sel_t;

endpackage

// ---- rtl/lcim_top.sv ----
// The APB slave port was left to the implementer.
`include "lcim_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module lcim_top #(
   parameter int NUM_CH = 16
) (
   input  wire logic                   MCLK_I,
   input  wire logic                   RST_B_I,
   input  wire logic                   PSEL_I,
   input  wire logic                   PENABLE_I,
   input  wire logic                   PWRITE_I,
   input  wire logic [12:0]            PADDR_I,
   input  wire logic [31:0]            PWDATA_I,
   input  wire logic [3:0]             PSTRB_I,
   output logic      [31:0]            PRDATA_O,
   output logic                        PREADY_O,
   output logic                        PSLVERR_O,
   input  wire logic [NUM_CH-1:0][7:0] COND_LIVE_CONDITION_STATUS0_I,
   input  wire logic [NUM_CH-1:0][7:0] COND_STAT1_I,
   input  wire logic [NUM_CH-1:0][7:0] EVENT_GROUP0_I,
   input  wire logic [NUM_CH-1:0][7:0] EVENT_GROUP2_I,
   output logic                        IRQ_O
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CH-1:0][7:0] mask0;
      logic [NUM_CH-1:0][7:0] mask1;
      logic [NUM_CH-1:0][7:0] mask2;
      logic [NUM_CH-1:0][7:0] edge_sel;
      logic [NUM_CH-1:0][7:0] flag0;
      logic [NUM_CH-1:0][7:0] flag1;
      logic [NUM_CH-1:0][7:0] flag2;
      logic [NUM_CH-1:0][7:0] live_condition_status0;
      logic [NUM_CH-1:0][7:0] stat1;
      logic [7:0]             gmask0;
      logic [31:0]            prdata;
      logic                   ready;
      logic                   slverr;
      logic                   irq;
   } lcim_state_t;

   lcim_state_t st_reg;
   lcim_state_t st_next;

   // -------------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------------
   logic [`LCIM_IDX_W-1:0] idx;
   logic [5:0]             ofs;
   logic [3:0]             ch;
   lcim_pkg::lcim_sel_t    sel;
   logic                   in_block;

   assign idx      = PADDR_I[12:2];
   assign ofs      = idx[5:0];
   assign ch       = idx[9:6];
   // Channel n sits 0x40 indices above channel n-1; the block from channel 9
   // onward starts at its own base, which lands on the same stride here.
   assign in_block = (idx[10] == 1'b0) && (int'(ch) < NUM_CH)
                     && (ofs >= `LCIM_OFS_EDGE_SEL) && (ofs <= `LCIM_OFS_FLAG2);

   always_comb begin
      sel = lcim_pkg::LCIM_SEL_NONE;
      if (idx == `LCIM_GMASK0_IDX) begin
         sel = lcim_pkg::LCIM_SEL_GMASK0;
      end else if (in_block) begin
         unique case (ofs)
            `LCIM_OFS_EDGE_SEL: sel = lcim_pkg::LCIM_SEL_EDGE_SEL;
            `LCIM_OFS_MASK0:    sel = lcim_pkg::LCIM_SEL_MASK0;
            `LCIM_OFS_MASK1:    sel = lcim_pkg::LCIM_SEL_MASK1;
            `LCIM_OFS_MASK2:    sel = lcim_pkg::LCIM_SEL_MASK2;
            `LCIM_OFS_LIVE_CONDITION_STATUS0:    sel = lcim_pkg::LCIM_SEL_LIVE_CONDITION_STATUS0;
            `LCIM_OFS_STAT1:    sel = lcim_pkg::LCIM_SEL_STAT1;
            `LCIM_OFS_FLAG0:    sel = lcim_pkg::LCIM_SEL_FLAG0;
            `LCIM_OFS_FLAG1:    sel = lcim_pkg::LCIM_SEL_FLAG1;
            `LCIM_OFS_FLAG2:    sel = lcim_pkg::LCIM_SEL_FLAG2;
            default:            sel = lcim_pkg::LCIM_SEL_NONE;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Bus phases
   // -------------------------------------------------------------------------
   logic setup_phase;
   logic wr_done;
   logic wr_low;

   assign setup_phase = PSEL_I && !PENABLE_I;
   assign wr_done     = PSEL_I && PENABLE_I && st_reg.ready && PWRITE_I;
   assign wr_low      = wr_done && PSTRB_I[0] && (sel != lcim_pkg::LCIM_SEL_NONE);

   // -------------------------------------------------------------------------
   // Per-channel flag set terms
   // -------------------------------------------------------------------------
   logic [NUM_CH-1:0][7:0] set0;
   logic [NUM_CH-1:0][7:0] set1;
   logic [NUM_CH-1:0][7:0] set2;
   logic [NUM_CH-1:0][7:0] both0;
   logic [NUM_CH-1:0][7:0] both1;
   logic [NUM_CH-1:0][7:0] eff_mask0;
   logic [NUM_CH-1:0]      pend;

   genvar gc;
   generate
      for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
         logic [7:0] rise0;
         logic [7:0] fall0;
         logic [7:0] rise1;
         logic [7:0] fall1;
         logic [7:0] es;

         assign es    = st_reg.edge_sel[gc];
         assign rise0 = COND_LIVE_CONDITION_STATUS0_I[gc] & ~st_reg.live_condition_status0[gc];
         assign fall0 = ~COND_LIVE_CONDITION_STATUS0_I[gc] & st_reg.live_condition_status0[gc];
         assign rise1 = COND_STAT1_I[gc] & ~st_reg.stat1[gc];
         assign fall1 = ~COND_STAT1_I[gc] & st_reg.stat1[gc];

         // Edge-select bits cover one or two status bits each.
         assign both0[gc] = {3'h0, es[`LCIM_ES_TOC], es[`LCIM_ES_TCKLOS],
                             es[`LCIM_ES_TLOS], es[`LCIM_ES_LOS], es[`LCIM_ES_LOS]};
         assign both1[gc] = {es[`LCIM_ES_AIS], es[`LCIM_ES_AIS], es[`LCIM_ES_PA],
                             3'h0, es[`LCIM_ES_IB], es[`LCIM_ES_IB]};

         // Level conditions set flags by edges, one-shot detectors by pulses.
         assign set0[gc] = {EVENT_GROUP0_I[gc][7:5],
                            (rise0[4:0] | (fall0[4:0] & both0[gc][4:0]))};
         assign set1[gc] = (rise1 | (fall1 & both1[gc])) & `LCIM_BITS_GROUP1;
         assign set2[gc] = EVENT_GROUP2_I[gc] & `LCIM_BITS_GROUP2;

         // The global copy masks group0 sources in every channel at once.
         assign eff_mask0[gc] = st_reg.mask0[gc] | st_reg.gmask0;

         // Mask one suppresses, zero passes the flag to the output.
         assign pend[gc] = |(st_reg.flag0[gc] & ~eff_mask0[gc])
                         | |(st_reg.flag1[gc] & ~st_reg.mask1[gc])
                         | |(st_reg.flag2[gc] & ~st_reg.mask2[gc]);
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Read mux
   // -------------------------------------------------------------------------
   lcim_pkg::lcim_byte_t rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      if (int'(ch) < NUM_CH) begin
         unique case (sel)
            lcim_pkg::LCIM_SEL_EDGE_SEL: rd_byte = st_reg.edge_sel[ch];
            lcim_pkg::LCIM_SEL_MASK0:    rd_byte = st_reg.mask0[ch];
            lcim_pkg::LCIM_SEL_MASK1:    rd_byte = st_reg.mask1[ch];
            lcim_pkg::LCIM_SEL_MASK2:    rd_byte = st_reg.mask2[ch];
            lcim_pkg::LCIM_SEL_LIVE_CONDITION_STATUS0:    rd_byte = st_reg.live_condition_status0[ch] & `LCIM_BITS_LIVE_CONDITION_STATUS0;
            lcim_pkg::LCIM_SEL_STAT1:    rd_byte = st_reg.stat1[ch] & `LCIM_BITS_GROUP1;
            lcim_pkg::LCIM_SEL_FLAG0:    rd_byte = st_reg.flag0[ch];
            lcim_pkg::LCIM_SEL_FLAG1:    rd_byte = st_reg.flag1[ch];
            lcim_pkg::LCIM_SEL_FLAG2:    rd_byte = st_reg.flag2[ch];
            lcim_pkg::LCIM_SEL_GMASK0:   rd_byte = st_reg.gmask0;
            lcim_pkg::LCIM_SEL_NONE:     rd_byte = 8'h00;
         endcase
      end else if (sel == lcim_pkg::LCIM_SEL_GMASK0) begin
         rd_byte = st_reg.gmask0;
      end
   end

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      logic [7:0] wb;
      logic       hit;
      wb      = PWDATA_I[7:0];
      hit     = 1'b0;
      st_next = st_reg;

      // One wait-free access cycle: ready rises in the cycle after setup.
      st_next.ready = setup_phase;
      if (setup_phase) begin
         st_next.prdata = {24'h00_0000, rd_byte};
         st_next.slverr = (sel == lcim_pkg::LCIM_SEL_NONE);
      end else if (!PSEL_I) begin
         st_next.slverr = 1'b0;
      end

      if (wr_low && sel == lcim_pkg::LCIM_SEL_GMASK0) begin
         st_next.gmask0 = wb;
      end

      for (int c = 0; c < NUM_CH; c++) begin
         hit = wr_low && (int'(ch) == c);
         // Status registers are live copies; stat is also the edge history.
         st_next.live_condition_status0[c] = COND_LIVE_CONDITION_STATUS0_I[c] & `LCIM_BITS_LIVE_CONDITION_STATUS0;
         st_next.stat1[c] = COND_STAT1_I[c] & `LCIM_BITS_GROUP1;

         if (hit && sel == lcim_pkg::LCIM_SEL_MASK0) begin
            st_next.mask0[c] = wb & `LCIM_BITS_GROUP0;
         end
         if (hit && sel == lcim_pkg::LCIM_SEL_MASK1) begin
            st_next.mask1[c] = wb & `LCIM_BITS_GROUP1;
         end
         if (hit && sel == lcim_pkg::LCIM_SEL_MASK2) begin
            st_next.mask2[c] = wb & `LCIM_BITS_GROUP2;
         end
         if (hit && sel == lcim_pkg::LCIM_SEL_EDGE_SEL) begin
            st_next.edge_sel[c] = wb & `LCIM_BITS_EDGE_SEL;
         end

         // Write-one clears, but a set arriving in the same cycle wins.
         st_next.flag0[c] = (st_reg.flag0[c]
                            & ~((hit && sel == lcim_pkg::LCIM_SEL_FLAG0) ? wb : 8'h00))
                            | set0[c];
         st_next.flag1[c] = ((st_reg.flag1[c]
                            & ~((hit && sel == lcim_pkg::LCIM_SEL_FLAG1) ? wb : 8'h00))
                            | set1[c]) & `LCIM_BITS_GROUP1;
         st_next.flag2[c] = ((st_reg.flag2[c]
                            & ~((hit && sel == lcim_pkg::LCIM_SEL_FLAG2) ? wb : 8'h00))
                            | set2[c]) & `LCIM_BITS_GROUP2;
      end

      st_next.irq = |pend;
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         st_reg.mask0    <= {NUM_CH{`LCIM_RST_MASK0}};
         st_reg.mask1    <= {NUM_CH{`LCIM_RST_MASK1}};
         st_reg.mask2    <= {NUM_CH{`LCIM_RST_MASK2}};
         st_reg.edge_sel <= {NUM_CH{`LCIM_RST_EDGE_SEL}};
         st_reg.flag0    <= {NUM_CH{8'h00}};
         st_reg.flag1    <= {NUM_CH{8'h00}};
         st_reg.flag2    <= {NUM_CH{8'h00}};
         st_reg.live_condition_status0    <= {NUM_CH{`LCIM_RST_STAT}};
         st_reg.stat1    <= {NUM_CH{`LCIM_RST_STAT}};
         st_reg.gmask0   <= `LCIM_RST_MASK0;
         st_reg.prdata   <= 32'h0000_0000;
         st_reg.ready    <= 1'b0;
         st_reg.slverr   <= 1'b0;
         st_reg.irq      <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign PRDATA_O  = st_reg.prdata;
   assign PREADY_O  = st_reg.ready;
   assign PSLVERR_O = st_reg.slverr && st_reg.ready;
   assign IRQ_O     = st_reg.irq;

endmodule

`default_nettype wire

// ---- bench/lcim_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Port checks for the mask and status block.
// ----------------------------------------------------------------------------
module lcim_monitor #(
   parameter int NUM_CH = 16
) (
   input  wire logic                   MCLK_I,
   input  wire logic                   RST_B_I,
   input  wire logic                   PSEL_I,
   input  wire logic                   PENABLE_I,
   input  wire logic                   PWRITE_I,
   input  wire logic [12:0]            PADDR_I,
   input  wire logic [31:0]            PWDATA_I,
   input  wire logic [3:0]             PSTRB_I,
   input  wire logic [31:0]            PRDATA_O,
   input  wire logic                   PREADY_O,
   input  wire logic                   PSLVERR_O,
   input  wire logic [NUM_CH-1:0][7:0] COND_LIVE_CONDITION_STATUS0_I,
   input  wire logic [NUM_CH-1:0][7:0] COND_STAT1_I,
   input  wire logic [NUM_CH-1:0][7:0] EVENT_GROUP0_I,
   input  wire logic [NUM_CH-1:0][7:0] EVENT_GROUP2_I,
   input  wire logic                   IRQ_O
);
   logic       wrote_reg;
   logic [5:0] ofs;
   logic [7:0] stat_sel;
   assign ofs = PADDR_I[7:2];
   assign stat_sel = COND_LIVE_CONDITION_STATUS0_I[PADDR_I[12:8]];
   default clocking @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_B_I);
   sequence s_setup;
      PSEL_I && !PENABLE_I;
   endsequence
   sequence s_status_read;
      s_setup ##0 (!PWRITE_I && ofs == 6'h1E && PADDR_I[12:8] < NUM_CH && $stable(COND_LIVE_CONDITION_STATUS0_I));
   endsequence
   // Until software has written anything, every source must still be masked.
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         wrote_reg <= 1'b0;
      end else if (PSEL_I && PENABLE_I && PWRITE_I && PREADY_O) begin
         wrote_reg <= 1'b1;
      end
   end
   a_ready_next: assert property (s_setup |=> PREADY_O)
      else $error("PREADY_O missing after setup.");
   a_ready_single: assert property (PREADY_O |=> !PREADY_O)
      else $error("PREADY_O held too long.");
   a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O && PSEL_I && PENABLE_I)
      else $error("PSLVERR_O outside access.");
   a_rdata_upper: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h000000)
      else $error("Upper read data not zero.");
   a_quiet_start: assert property (!wrote_reg |-> !IRQ_O)
      else $error("IRQ_O before any mask write.");
   a_unmapped_err: assert property (s_setup ##0 (ofs < 6'h1A || ofs > 6'h22) |=> PSLVERR_O)
      else $error("No error on unmapped access.");
   a_mapped_ok: assert property (s_setup ##0 (ofs >= 6'h1A && ofs <= 6'h22 &&
      PADDR_I[12:8] < NUM_CH) |=> !PSLVERR_O)
      else $error("Error on mapped access.");
   a_status_live: assert property (s_status_read |=> PRDATA_O[7:0] == ($past(stat_sel) & 8'h9F))
      else $error("Status read differs from live conditions.");
endmodule
bind lcim_top lcim_monitor #(.NUM_CH(NUM_CH)) i_monitor (
   .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
   .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .COND_LIVE_CONDITION_STATUS0_I(COND_LIVE_CONDITION_STATUS0_I), .COND_STAT1_I(COND_STAT1_I),
   .EVENT_GROUP0_I(EVENT_GROUP0_I), .EVENT_GROUP2_I(EVENT_GROUP2_I), .IRQ_O(IRQ_O));
`default_nettype wire

// ---- bench/lcim_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Host processor on the register bus.
// ----------------------------------------------------------------------------
module lcim_host (
   input  wire logic        clk_i,
   input  wire logic        pready_i,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pslverr_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [12:0]      paddr_o,
   output logic [31:0]      pwdata_o
);
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 13'h0000;
      pwdata_o = 32'h00000000;
   end
   task automatic xfer(input logic w, input logic [10:0] idx, input logic [7:0] d,
                       output logic [7:0] q, output logic err);
      @(posedge clk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= w;
      paddr_o <= {idx, 2'b00};
      pwdata_o <= {24'h000000, d};
      @(posedge clk_i);
      penable_o <= 1'b1;
      @(posedge clk_i);
      while (pready_i !== 1'b1) begin
         @(posedge clk_i);
      end
      q = prdata_i[7:0];
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // A released bus shows no stale request, so inverted values are left behind.
      paddr_o <= ~paddr_o;
      pwdata_o <= ~pwdata_o;
   endtask
endmodule
`default_nettype wire

// ---- bench/lcim_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Self-checking bench.
// ----------------------------------------------------------------------------
module lcim_top_bench;
   localparam int NCH = 2;
   logic                clk = 1'b0;
   logic                rst_b = 1'b0;
   logic                psel, penable, pwrite, pready, pslverr, irq, e;
   logic [12:0]         paddr;
   logic [31:0]         pwdata, prdata;
   logic [7:0]          q;
   logic [NCH-1:0][7:0] cond0 = '0, cond1 = '0, ev0 = '0, ev2 = '0;
   int                  n_mismatch = 0, checks = 0, cyc = 0;
   logic [2:0][7:0]     impl = {8'h3F, 8'hE3, 8'hFF};
   always #4 clk = ~clk;
   lcim_top #(.NUM_CH(NCH)) i_dut (.MCLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PSTRB_I(4'hF), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .COND_LIVE_CONDITION_STATUS0_I(cond0), .COND_STAT1_I(cond1), .EVENT_GROUP0_I(ev0),
      .EVENT_GROUP2_I(ev2), .IRQ_O(irq));
   lcim_host i_host (.clk_i(clk), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr),
      .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [10:0] ix(input int ch, input int ofs);
      return 11'(ch * 64 + ofs);
   endfunction
   task automatic wr(input logic [10:0] idx, input logic [7:0] d);
      i_host.xfer(1'b1, idx, d, q, e);
   endtask
   task automatic rd(input logic [10:0] idx, input logic [7:0] exp, input string what);
      i_host.xfer(1'b0, idx, 8'h00, q, e);
      chk(what, exp, q);
   endtask
   task automatic irq_is(input logic exp);
      repeat (2) @(posedge clk);
      #1 chk("IRQ_O", {7'h00, exp}, {7'h00, irq});
   endtask
   // Conditions are levels; FIFO, amplitude, violation and counter sources are pulses.
   task automatic src(input int ch, input int g, input int b, input logic v);
      @(posedge clk);
      if (g == 1) cond1[ch][b] <= v;
      else if (g == 0 && b < 5) cond0[ch][b] <= v;
      else if (v) begin
         if (g == 0) ev0[ch][b] <= 1'b1;
         else ev2[ch][b] <= 1'b1;
         @(posedge clk);
         ev0[ch] <= 8'h00;
         ev2[ch] <= 8'h00;
      end
      @(posedge clk);
   endtask
   task automatic t_reset_values();
      rd(11'h7DB, 8'hFF, "global mask");
      for (int ch = 0; ch < NCH; ch++) begin
         for (int g = 0; g < 3; g++) rd(ix(ch, 'h1B + g), impl[g], "mask reset");
         rd(ix(ch, 'h1E), 8'h00, "status reset");
      end
   endtask
   task automatic t_reserved();
      for (int ch = 0; ch < NCH; ch++) begin
         for (int g = 0; g < 3; g++) begin
            wr(ix(ch, 'h1B + g), 8'h00);
            rd(ix(ch, 'h1B + g), 8'h00, "mask clear");
            wr(ix(ch, 'h1B + g), 8'hFF);
            rd(ix(ch, 'h1B + g), impl[g], "mask reserved");
         end
         wr(ix(ch, 'h1E), 8'hFF);
         rd(ix(ch, 'h1E), 8'h00, "status write");
         cond0[ch] <= 8'hFF;
         repeat (2) @(posedge clk);
         rd(ix(ch, 'h1E), 8'h9F, "status live");
         cond0[ch] <= 8'h00;
         repeat (2) @(posedge clk);
         rd(ix(ch, 'h1E), 8'h00, "status idle");
         wr(ix(ch, 'h20), 8'hFF);
      end
   endtask
   task automatic t_sources();
      wr(11'h7DB, 8'h00);
      for (int ch = 0; ch < NCH; ch++)
         for (int g = 0; g < 3; g++)
            for (int b = 0; b < 8; b++) if (impl[g][b]) begin
               src(ch, g, b, 1'b1);
               rd(ix(ch, 'h20 + g), 8'(1 << b), "flag set");
               irq_is(1'b0);
               wr(ix(ch, 'h1B + g), ~8'(1 << b));
               irq_is(1'b1);
               if (g == 0) begin
                  wr(11'h7DB, 8'(1 << b));
                  irq_is(1'b0);
                  wr(11'h7DB, 8'h00);
               end
               wr(ix(ch, 'h20 + g), 8'(1 << b));
               irq_is(1'b0);
               src(ch, g, b, 1'b0);
               rd(ix(ch, 'h20 + g), 8'h00, "flag after fall");
               wr(ix(ch, 'h1B + g), 8'hFF);
            end
   endtask
   task automatic t_edge_and_unmapped();
      src(1, 0, 4, 1'b1);
      wr(ix(1, 'h20), 8'hFF);
      wr(ix(1, 'h1A), 8'h10);
      src(1, 0, 4, 1'b0);
      rd(ix(1, 'h20), 8'h10, "flag on fall");
      rd(11'h000, 8'h00, "unmapped data");
      chk("unmapped error", 8'h01, {7'h00, e});
   endtask
   task automatic print_verdict();
      if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      t_reset_values();
      t_reserved();
      t_sources();
      t_edge_and_unmapped();
      print_verdict();
   end
endmodule
`default_nettype wire
